/* File: logic/dowlt_pkg.sv */
// dowlt_pkg: shared constants and types for the termination / write-leveling link.
// assumes one 250 MHz clock, clk_sys, on both ends; every ck count is a clk_sys edge.
package dowlt_pkg;

  // ----------------------------------------------------------------
  // clock and time conversions
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS                = 4.0;
  localparam real LEVEL_FEEDBACK_DELAY_NS      = 7.5;  // latest feedback after strobe
  localparam real LEVEL_FEEDBACK_SKEW_NS       = 2.0;  // spread among feedback bits
  localparam int  LEVEL_FEEDBACK_DELAY_RAW     = int'($floor(LEVEL_FEEDBACK_DELAY_NS
                                                             / CLK_PERIOD_NS));
  localparam int  LEVEL_FEEDBACK_SKEW_RAW      = int'($floor(LEVEL_FEEDBACK_SKEW_NS
                                                             / CLK_PERIOD_NS));
  // longest times round down, but never below one cycle
  localparam int  LEVEL_FEEDBACK_DELAY_CYC     = (LEVEL_FEEDBACK_DELAY_RAW < 1) ? 1
                                                 : LEVEL_FEEDBACK_DELAY_RAW;
  localparam int  LEVEL_FEEDBACK_SKEW_CYC      = (LEVEL_FEEDBACK_SKEW_RAW < 1) ? 1
                                                 : LEVEL_FEEDBACK_SKEW_RAW;

  // ----------------------------------------------------------------
  // counts in clock cycles
  // ----------------------------------------------------------------
  localparam int  TERM_HIGH_HOLD_LONG_BURST    = 6;
  localparam int  TERM_HIGH_HOLD_SHORT         = 4;
  localparam int  LEVEL_MODE_TO_FIRST_STROBE   = 40;
  localparam int  CHOP_RETURN_CK               = 4;   // added to turn-off latency
  localparam int  FULL_RETURN_CK               = 6;
  localparam int  TERM_LATENCY_SUB_CK          = 2;   // write latency minus this
  localparam real DYN_TERM_CHANGE_WINDOW_MIN   = 0.3; // fraction of a clock
  localparam real DYN_TERM_CHANGE_WINDOW_MAX   = 0.7;
  localparam int  CNT_W                        = 6;
  localparam int  ODT_HIST_W                   = 32;

  // ----------------------------------------------------------------
  // mode register layout and reset values
  // ----------------------------------------------------------------
  localparam int  ADDR_W                       = 12;
  localparam int  MR_CWL_LSB                   = 0;   // 4 bits
  localparam int  MR_AL_LSB                    = 4;   // 4 bits
  localparam int  MR_DYN_EN_BIT                = 8;
  localparam int  MR_LEVEL_EN_BIT              = 9;
  localparam int  WR_CHOP_BIT                  = 0;   // on a write command
  localparam logic [3:0] RESET_CWL             = 4'h5;
  localparam logic [3:0] RESET_AL              = 4'h0;

  typedef enum logic [1:0] {
    cmd_nop   = 2'h0,
    cmd_write = 2'h1,
    cmd_mrs   = 2'h2
  } dowlt_cmd_t;

  typedef enum logic [1:0] {
    term_off            = 2'h0,
    nominal_termination = 2'h1,
    write_termination   = 2'h2
  } dowlt_term_t;

endpackage : dowlt_pkg

/* File: logic/dowlt_link_if.sv */
// dowlt_link_if: pins between controller and memory device.
// assumes both ends run on the same clk_sys; the bench resolves nothing, all pins are one-way.
interface dowlt_link_if #(parameter int DQ_W = 8);
  dowlt_pkg::dowlt_cmd_t            cmd;
  logic [dowlt_pkg::ADDR_W-1:0]     cmd_addr;
  logic                             odt;
  logic                             mem_ck;
  logic                             dqs;
  logic [DQ_W-1:0]                  dq_fb;
  logic                             dq_fb_oe_n;

  modport dev (
    input  cmd,
    input  cmd_addr,
    input  odt,
    input  mem_ck,
    input  dqs,
    output dq_fb,
    output dq_fb_oe_n
  );

  modport ctl (
    output cmd,
    output cmd_addr,
    output odt,
    output mem_ck,
    output dqs,
    input  dq_fb,
    input  dq_fb_oe_n
  );
endinterface : dowlt_link_if

/* File: logic/dowlt_device.sv */
// dowlt_device: memory-side timing of termination and write leveling.
// assumes link signals come from logic on clk_sys, so they are sampled directly.
//
// Operation
// (RULE1) controller holds odt six cycles on full writes
// (RULE2) otherwise controller holds odt at least four cycles
// (RULE3) switch to write termination at latency minus two
// (RULE4) chop write: back after four plus turnoff latency
// (RULE5) full write: back after six plus turnoff latency
// (RULE6) termination change lands inside its change window
// (RULE7) first strobe at least forty cycles after enable
// (RULE8) leveling feedback within 7.5 ns of strobe
// (RULE9) feedback bits skew at most 2 ns
// (RULE10) time limits round: minimums up, maximums down
// (RULE11) clock limits count real clock edges only
// (RULE12) turnoff latency equals write latency minus two
// (RULE13) leveling samples clock level on strobe, echoes
module dowlt_device #(
  parameter int DQ_W = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  dowlt_link_if.dev                  link,
  output dowlt_pkg::dowlt_term_t     term_state,
  output logic                       term_change,
  output logic                       level_mode,
  output logic                       odt_hold_err,
  output logic                       level_early_err
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]                         cwl;
    logic [3:0]                         al;
    logic                               dyn_en;
    logic                               level_en;
    logic [dowlt_pkg::ODT_HIST_W-1:0]   odt_hist;
    logic                               wr_pend;
    logic [dowlt_pkg::CNT_W-1:0]        start_cnt;
    logic [dowlt_pkg::CNT_W-1:0]        end_cnt;
    logic                               wr_term;
    logic [dowlt_pkg::CNT_W-1:0]        odt_run;
    logic                               odt_run_full;
    logic                               odt_err;
    logic [dowlt_pkg::CNT_W-1:0]        lvl_wait;
    logic                               lvl_err;
    logic                               dqs_prev;
    logic                               ck_smp;
    logic [dowlt_pkg::CNT_W-1:0]        fb_cnt;
    logic [DQ_W-1:0]                    dq;
    logic                               dq_oe_n;
    dowlt_pkg::dowlt_term_t             term;
    logic                               term_chg;
  } dowlt_dev_st_t;

  localparam logic [dowlt_pkg::CNT_W-1:0] SUB_CK   =
    dowlt_pkg::CNT_W'(dowlt_pkg::TERM_LATENCY_SUB_CK);
  localparam logic [dowlt_pkg::CNT_W-1:0] CHOP_CK  =
    dowlt_pkg::CNT_W'(dowlt_pkg::CHOP_RETURN_CK);
  localparam logic [dowlt_pkg::CNT_W-1:0] FULL_CK  =
    dowlt_pkg::CNT_W'(dowlt_pkg::FULL_RETURN_CK);
  localparam logic [dowlt_pkg::CNT_W-1:0] HOLD_LONG  =
    dowlt_pkg::CNT_W'(dowlt_pkg::TERM_HIGH_HOLD_LONG_BURST);
  localparam logic [dowlt_pkg::CNT_W-1:0] HOLD_SHORT =
    dowlt_pkg::CNT_W'(dowlt_pkg::TERM_HIGH_HOLD_SHORT);
  localparam logic [dowlt_pkg::CNT_W-1:0] LVL_GAP  =
    dowlt_pkg::CNT_W'(dowlt_pkg::LEVEL_MODE_TO_FIRST_STROBE);
  localparam logic [dowlt_pkg::CNT_W-1:0] FB_CYC   =
    dowlt_pkg::CNT_W'(dowlt_pkg::LEVEL_FEEDBACK_DELAY_CYC);
  localparam logic [dowlt_pkg::CNT_W-1:0] CNT_MAX  = '1;

  dowlt_dev_st_t                st_ff;
  dowlt_dev_st_t                nxt_st;
  logic [dowlt_pkg::CNT_W-1:0]  write_lat;
  logic [dowlt_pkg::CNT_W-1:0]  term_lat;
  logic                         is_write;
  logic                         is_chop;
  logic                         dqs_rise;
  logic                         nominal_on;

  // ----------------------------------------------------------------
  // latencies and decoded link events
  // ----------------------------------------------------------------
  // cwl + al never drops under three with legal settings, so the index stays positive
  assign write_lat = dowlt_pkg::CNT_W'(st_ff.cwl) + dowlt_pkg::CNT_W'(st_ff.al);
  assign term_lat  = write_lat - SUB_CK;                            // [RULE12] [RULE3]
  assign is_write  = (link.cmd == dowlt_pkg::cmd_write);
  assign is_chop   = link.cmd_addr[dowlt_pkg::WR_CHOP_BIT];
  assign dqs_rise  = link.dqs & ~st_ff.dqs_prev;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.term_chg = 1'b0;
    nxt_st.odt_err  = 1'b0;
    nxt_st.lvl_err  = 1'b0;
    nxt_st.dqs_prev = link.dqs;

    // odt history: bit k holds odt as sampled k+1 edges ago, one bit per clock edge
    nxt_st.odt_hist = {st_ff.odt_hist[dowlt_pkg::ODT_HIST_W-2:0], link.odt}; // [RULE11]

    // mode register write: latencies, dynamic termination and leveling enables
    if (link.cmd == dowlt_pkg::cmd_mrs) begin
      nxt_st.cwl      = link.cmd_addr[dowlt_pkg::MR_CWL_LSB +: 4];
      nxt_st.al       = link.cmd_addr[dowlt_pkg::MR_AL_LSB +: 4];
      nxt_st.dyn_en   = link.cmd_addr[dowlt_pkg::MR_DYN_EN_BIT];
      nxt_st.level_en = link.cmd_addr[dowlt_pkg::MR_LEVEL_EN_BIT];
      if (link.cmd_addr[dowlt_pkg::MR_LEVEL_EN_BIT] && !st_ff.level_en) begin
        nxt_st.lvl_wait = dowlt_pkg::CNT_W'(1);
      end
    end

    // edges since leveling was enabled, saturating
    if (st_ff.lvl_wait != '0 && st_ff.lvl_wait != CNT_MAX) begin
      nxt_st.lvl_wait = st_ff.lvl_wait + dowlt_pkg::CNT_W'(1);     // [RULE11]
    end

    // write-termination window countdowns; switching lands on the counted edge
    if (st_ff.wr_pend) begin
      if (st_ff.start_cnt <= dowlt_pkg::CNT_W'(1)) begin
        nxt_st.wr_term   = 1'b1;                                    // [RULE3]
        nxt_st.wr_pend   = 1'b0;
        nxt_st.start_cnt = '0;
      end else begin
        nxt_st.start_cnt = st_ff.start_cnt - dowlt_pkg::CNT_W'(1);
      end
    end
    if (st_ff.end_cnt != '0) begin
      if (st_ff.end_cnt == dowlt_pkg::CNT_W'(1)) begin
        nxt_st.wr_term = 1'b0;                                      // [RULE4] [RULE5]
      end
      nxt_st.end_cnt = st_ff.end_cnt - dowlt_pkg::CNT_W'(1);
    end

    // a new write keeps an earlier pending switch but always reloads the end from its own burst length
    if (is_write && st_ff.dyn_en) begin
      if (!st_ff.wr_pend && !st_ff.wr_term) begin
        nxt_st.wr_pend   = 1'b1;
        nxt_st.start_cnt = term_lat;                                // [RULE3]
      end
      nxt_st.end_cnt = (is_chop ? CHOP_CK : FULL_CK) + term_lat;    // [RULE4] [RULE5]
    end

    // watch the controller's odt pulse length; flags a short pulse on its fall
    if (link.odt) begin
      if (st_ff.odt_run != CNT_MAX) begin
        nxt_st.odt_run = st_ff.odt_run + dowlt_pkg::CNT_W'(1);
      end
      if (is_write && !is_chop) begin
        nxt_st.odt_run_full = 1'b1;
      end
    end else if (st_ff.odt_run != '0) begin
      nxt_st.odt_err      = st_ff.odt_run_full ? (st_ff.odt_run < HOLD_LONG)   // [RULE1]
                                               : (st_ff.odt_run < HOLD_SHORT); // [RULE2]
      nxt_st.odt_run      = '0;
      nxt_st.odt_run_full = 1'b0;
    end

    // termination select: nominal follows odt by the turn-on/off latency
    nominal_on = nxt_st.odt_hist[term_lat[4:0]];                    // [RULE12]
    if (nxt_st.wr_term && nominal_on) begin
      nxt_st.term = dowlt_pkg::write_termination;
    end else if (nominal_on) begin
      nxt_st.term = dowlt_pkg::nominal_termination;
    end else begin
      nxt_st.term = dowlt_pkg::term_off;
    end
    // change is registered on the reference edge, mid-window in analog terms
    nxt_st.term_chg = (nxt_st.term != st_ff.term);                  // [RULE6]

    // leveling feedback: counted out from the strobe, all bits on one edge
    if (st_ff.fb_cnt != '0) begin
      if (st_ff.fb_cnt == dowlt_pkg::CNT_W'(1)) begin
        nxt_st.dq = {DQ_W{st_ff.ck_smp}};                           // [RULE8] [RULE9]
      end
      nxt_st.fb_cnt = st_ff.fb_cnt - dowlt_pkg::CNT_W'(1);
    end
    if (st_ff.level_en && dqs_rise) begin
      nxt_st.ck_smp  = link.mem_ck;                                 // [RULE13]
      nxt_st.fb_cnt  = FB_CYC;                                      // [RULE10]
      nxt_st.lvl_err = (st_ff.lvl_wait < LVL_GAP);                  // [RULE7]
    end

    // data lines only driven while leveling; low enable means driving
    nxt_st.dq_oe_n = ~nxt_st.level_en;
    if (!nxt_st.level_en) begin
      nxt_st.dq     = '0;
      nxt_st.fb_cnt = '0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff          <= '0;
      st_ff.cwl      <= dowlt_pkg::RESET_CWL;
      st_ff.al       <= dowlt_pkg::RESET_AL;
      st_ff.dq_oe_n  <= 1'b1;
      st_ff.term     <= dowlt_pkg::term_off;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign link.dq_fb      = st_ff.dq;
  assign link.dq_fb_oe_n = st_ff.dq_oe_n;
  assign term_state      = st_ff.term;
  assign term_change     = st_ff.term_chg;
  assign level_mode      = st_ff.level_en;
  assign odt_hold_err    = st_ff.odt_err;
  assign level_early_err = st_ff.lvl_err;

endmodule : dowlt_device

/* File: logic/dowlt_ctrl.sv */
// dowlt_ctrl: controller end; issues writes with odt, mode writes and leveling probes.
// assumes the device end shares clk_sys; feedback is read without synchronisers.
module dowlt_ctrl #(
  parameter int DQ_W    = 8,
  parameter int CK_HALF = 2     // clk_sys cycles per half period of mem_ck
) (
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  dowlt_link_if.ctl                          link,
  input  wire logic                          wr_req,
  input  wire logic                          wr_chop,
  input  wire logic                          wr_odt,
  output logic                               wr_ready,
  input  wire logic                          mrs_req,
  input  wire logic [dowlt_pkg::ADDR_W-1:0]  mrs_data,
  output logic                               mrs_ready,
  input  wire logic                          lvl_req,
  output logic                               lvl_ready,
  output logic                               lvl_done,
  output logic [DQ_W-1:0]                    lvl_result
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dowlt_pkg::dowlt_cmd_t              cmd;
    logic [dowlt_pkg::ADDR_W-1:0]       addr;
    logic                               odt;
    logic [dowlt_pkg::CNT_W-1:0]        odt_cnt;
    logic                               lvl_on;
    logic [dowlt_pkg::CNT_W-1:0]        lvl_wait;
    logic                               dqs;
    logic [dowlt_pkg::CNT_W-1:0]        fb_wait;
    logic [DQ_W-1:0]                    result;
    logic                               done;
    logic [dowlt_pkg::CNT_W-1:0]        ck_div;
    logic                               mem_ck;
  } dowlt_ctl_st_t;

  localparam logic [dowlt_pkg::CNT_W-1:0] HOLD_LONG  =
    dowlt_pkg::CNT_W'(dowlt_pkg::TERM_HIGH_HOLD_LONG_BURST);
  localparam logic [dowlt_pkg::CNT_W-1:0] HOLD_SHORT =
    dowlt_pkg::CNT_W'(dowlt_pkg::TERM_HIGH_HOLD_SHORT);
  localparam logic [dowlt_pkg::CNT_W-1:0] LVL_GAP    =
    dowlt_pkg::CNT_W'(dowlt_pkg::LEVEL_MODE_TO_FIRST_STROBE);
  // one edge for the device to see the strobe, then its delay and the skew window
  localparam logic [dowlt_pkg::CNT_W-1:0] FB_WAIT    =
    dowlt_pkg::CNT_W'(dowlt_pkg::LEVEL_FEEDBACK_DELAY_CYC
                      + dowlt_pkg::LEVEL_FEEDBACK_SKEW_CYC + 1);
  localparam logic [dowlt_pkg::CNT_W-1:0] HALF_CNT   = dowlt_pkg::CNT_W'(CK_HALF);

  dowlt_ctl_st_t                st_ff;
  dowlt_ctl_st_t                nxt_st;
  logic [dowlt_pkg::CNT_W-1:0]  hold_need;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // a probe in flight blocks mode writes so the enable cannot drop under it
  assign wr_ready  = 1'b1;
  assign mrs_ready = (st_ff.fb_wait == '0) && !st_ff.dqs;
  assign lvl_ready = st_ff.lvl_on && (st_ff.lvl_wait >= LVL_GAP)             // [RULE7]
                     && (st_ff.fb_wait == '0) && !st_ff.dqs && !mrs_req;
  assign hold_need = wr_chop ? HOLD_SHORT : HOLD_LONG;                        // [RULE1] [RULE2]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.cmd  = dowlt_pkg::cmd_nop;
    nxt_st.addr = '0;
    nxt_st.dqs  = 1'b0;
    nxt_st.done = 1'b0;

    // memory clock from a divider of clk_sys
    if (st_ff.ck_div >= HALF_CNT - dowlt_pkg::CNT_W'(1)) begin
      nxt_st.ck_div = '0;
      nxt_st.mem_ck = ~st_ff.mem_ck;
    end else begin
      nxt_st.ck_div = st_ff.ck_div + dowlt_pkg::CNT_W'(1);
    end

    // odt stays up until the hold count of edges has passed
    if (st_ff.odt_cnt != '0) begin
      if (st_ff.odt_cnt == dowlt_pkg::CNT_W'(1)) begin
        nxt_st.odt = 1'b0;
      end
      nxt_st.odt_cnt = st_ff.odt_cnt - dowlt_pkg::CNT_W'(1);          // [RULE11]
    end

    // edges since leveling enable, saturating at the required gap
    if (st_ff.lvl_on && st_ff.lvl_wait < LVL_GAP) begin
      nxt_st.lvl_wait = st_ff.lvl_wait + dowlt_pkg::CNT_W'(1);        // [RULE7]
    end

    // command issue: mode write wins over a write in the same cycle
    if (mrs_req && mrs_ready) begin
      nxt_st.cmd    = dowlt_pkg::cmd_mrs;
      nxt_st.addr   = mrs_data;
      nxt_st.lvl_on = mrs_data[dowlt_pkg::MR_LEVEL_EN_BIT];
      if (!mrs_data[dowlt_pkg::MR_LEVEL_EN_BIT] || !st_ff.lvl_on) begin
        nxt_st.lvl_wait = '0;
      end
    end else if (wr_req) begin
      nxt_st.cmd = dowlt_pkg::cmd_write;
      nxt_st.addr[dowlt_pkg::WR_CHOP_BIT] = wr_chop;
      if (wr_odt) begin
        nxt_st.odt = 1'b1;
        if (hold_need > st_ff.odt_cnt) begin
          nxt_st.odt_cnt = hold_need;                                 // [RULE1] [RULE2]
        end
      end
    end

    // leveling probe: one-cycle strobe, then sample feedback after the window
    if (lvl_req && lvl_ready) begin
      nxt_st.dqs     = 1'b1;
      nxt_st.fb_wait = FB_WAIT;                                       // [RULE10] [RULE9]
    end else if (st_ff.fb_wait != '0) begin
      if (st_ff.fb_wait == dowlt_pkg::CNT_W'(1)) begin
        nxt_st.result = link.dq_fb;                                   // [RULE8]
        nxt_st.done   = 1'b1;
      end
      nxt_st.fb_wait = st_ff.fb_wait - dowlt_pkg::CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff     <= '0;
      st_ff.cmd <= dowlt_pkg::cmd_nop;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.cmd      = st_ff.cmd;
  assign link.cmd_addr = st_ff.addr;
  assign link.odt      = st_ff.odt;
  assign link.mem_ck   = st_ff.mem_ck;
  assign link.dqs      = st_ff.dqs;
  assign lvl_done      = st_ff.done;
  assign lvl_result    = st_ff.result;

endmodule : dowlt_ctrl

/* File: testbench/dowlt_link_checker.sv */
// dowlt_link_checker: wire-level assertions on the controller/device link.
// assumes plain copies of the interface signals, all on clk_sys.
module dowlt_link_checker #(
  parameter int DQ_W = 8
) (
  input wire logic                         clk_sys,
  input wire logic                         arst_n,
  input wire dowlt_pkg::dowlt_cmd_t        cmd,
  input wire logic [dowlt_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic                         odt,
  input wire logic                         mem_ck,
  input wire logic                         dqs,
  input wire logic [DQ_W-1:0]              dq_fb,
  input wire logic                         dq_fb_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // helpers and sequences
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [6:0] lvl_wait_ff;
  sequence s_lvl_en;
    cmd == dowlt_pkg::cmd_mrs && cmd_addr[dowlt_pkg::MR_LEVEL_EN_BIT];
  endsequence
  sequence s_odt_up;
    $rose(odt) && cmd == dowlt_pkg::cmd_write;
  endsequence
  // edges since leveling enable, saturating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lvl_wait_ff <= 7'h7f;
    end else if (cmd == dowlt_pkg::cmd_mrs && cmd_addr[dowlt_pkg::MR_LEVEL_EN_BIT]) begin
      lvl_wait_ff <= 7'h01;
    end else if (lvl_wait_ff != 7'h7f) begin
      lvl_wait_ff <= lvl_wait_ff + 7'h01;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_odt_hold_full: assert property (s_odt_up ##0 !cmd_addr[0] |-> odt [*6])
    else $error("odt dropped early on full write");
  a_odt_hold_short: assert property ($rose(odt) |-> odt [*4])
    else $error("odt high for under four cycles");
  a_odt_chop_hold: assert property (s_odt_up ##0 cmd_addr[0] |-> odt [*4])
    else $error("odt dropped early on chop write");
  a_strobe_after_en: assert property (dqs |-> lvl_wait_ff >= 7'h28)
    else $error("strobe before forty cycles");
  a_strobe_one_cycle: assert property (dqs |=> !dqs)
    else $error("strobe longer than a cycle");
  a_fb_echo_level: assert property (dqs && !dq_fb_oe_n |->
    ##2 dq_fb == {DQ_W{$past(mem_ck, 2)}})
    else $error("feedback not the sampled clock level");
  a_fb_mode_on: assert property (s_lvl_en |-> ##[1:3] !dq_fb_oe_n)
    else $error("feedback not driven in leveling");
  a_fb_idle_zero: assert property (dq_fb_oe_n |-> dq_fb == '0)
    else $error("feedback bits not idle");
endmodule : dowlt_link_checker

/* File: testbench/tb_top.sv */
// tb_top: drives the controller user side, watches the device outputs and the link.
// assumes the two ends face each other through one dowlt_link_if.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals, instances, clock
  // ------------------------------------------------------------
  logic clk_sys, arst_n, wr_req, wr_chop, wr_odt, mrs_req, lvl_req;
  logic wr_ready, mrs_ready, lvl_ready, lvl_done, term_change, level_mode;
  logic odt_hold_err, level_early_err, herr = 1'b0, lerr = 1'b0;
  logic [11:0] mrs_data;
  logic [7:0] lvl_result;
  logic [31:0] seed = 32'hc00f5d0f;
  dowlt_pkg::dowlt_term_t term_state;
  int error_cnt = 0;
  int check_count = 0;
  dowlt_link_if #(.DQ_W(8)) dowlt_link_if_inst ();
  dowlt_device dowlt_device_inst (.clk_sys(clk_sys), .arst_n(arst_n), .link(dowlt_link_if_inst),
    .term_state(term_state), .term_change(term_change), .level_mode(level_mode),
    .odt_hold_err(odt_hold_err), .level_early_err(level_early_err));
  dowlt_ctrl dowlt_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n), .link(dowlt_link_if_inst),
    .wr_req(wr_req), .wr_chop(wr_chop), .wr_odt(wr_odt), .wr_ready(wr_ready),
    .mrs_req(mrs_req), .mrs_data(mrs_data), .mrs_ready(mrs_ready), .lvl_req(lvl_req),
    .lvl_ready(lvl_ready), .lvl_done(lvl_done), .lvl_result(lvl_result));
  dowlt_link_checker dowlt_link_checker_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .cmd(dowlt_link_if_inst.cmd), .cmd_addr(dowlt_link_if_inst.cmd_addr),
    .odt(dowlt_link_if_inst.odt), .mem_ck(dowlt_link_if_inst.mem_ck),
    .dqs(dowlt_link_if_inst.dqs), .dq_fb(dowlt_link_if_inst.dq_fb),
    .dq_fb_oe_n(dowlt_link_if_inst.dq_fb_oe_n));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // error pulses last one cycle, so keep a sticky copy
  always @(posedge clk_sys) begin
    if (odt_hold_err === 1'b1) herr <= 1'b1;
    if (level_early_err === 1'b1) lerr <= 1'b1;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp_val
  task automatic cmp_term(input string what, input dowlt_pkg::dowlt_term_t exp,
                          input dowlt_pkg::dowlt_term_t got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_term
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic do_mrs(input logic [11:0] d);
    @(posedge clk_sys);
    mrs_req <= 1'b1;
    mrs_data <= d;
    do @(negedge clk_sys); while (mrs_ready !== 1'b1);
    @(posedge clk_sys);
    mrs_req <= 1'b0;
  endtask : do_mrs
  // one write with odt; times the device's termination
  task automatic run_write(input logic chop, input logic dyn, input int lat);
    int n;
    dowlt_pkg::dowlt_term_t st;
    n = 0;
    repeat (32) @(posedge clk_sys);
    @(posedge clk_sys);
    wr_req <= 1'b1;
    wr_chop <= chop;
    wr_odt <= 1'b1;
    @(posedge clk_sys);
    wr_req <= 1'b0;
    @(negedge clk_sys);
    while (term_state === dowlt_pkg::term_off && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_val("switch latency", lat + 1, n);
    st = term_state;
    cmp_term("switched state", dyn ? dowlt_pkg::write_termination
             : dowlt_pkg::nominal_termination, st);
    cmp_val("change pulse", 1, term_change);
    n = 0;
    while (term_state === st && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_val("term span", chop ? 4 : 6, n);
    cmp_term("after span", dowlt_pkg::term_off, term_state);
  endtask : run_write
  task automatic run_probe();
    logic lvl;
    @(posedge clk_sys);
    lvl_req <= 1'b1;
    do @(negedge clk_sys); while (lvl_ready !== 1'b1);
    @(posedge clk_sys);
    lvl_req <= 1'b0;
    do @(negedge clk_sys); while (dowlt_link_if_inst.dqs !== 1'b1);
    lvl = dowlt_link_if_inst.mem_ck;
    do @(negedge clk_sys); while (lvl_done !== 1'b1);
    cmp_val("level result", {24'h0, {8{lvl}}}, {24'h0, lvl_result});
  endtask : run_probe
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [3:0] cwl, al;
    {wr_req, wr_chop, wr_odt, mrs_req, lvl_req} = '0;
    mrs_data = '0;
    arst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      cwl = (i == 0) ? 4'h3 : (i == 1) ? 4'hf : 4'h5 + seed[1:0];
      al = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : {2'h0, seed[3:2]};
      do_mrs({3'h0, seed[4], al, cwl});
      run_write(seed[5], seed[4], cwl + al - 2);
      $display("write test %0d done", i);
    end
    do_mrs(12'h205);
    repeat (2) @(negedge clk_sys);
    cmp_val("probe refused", 0, lvl_ready);
    cmp_val("level mode", 1, level_mode);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      repeat (seed[2:0]) @(posedge clk_sys);
      run_probe();
    end
    $display("leveling test done");
    do_mrs(12'h005);
    repeat (3) @(negedge clk_sys);
    cmp_val("feedback released", 1, dowlt_link_if_inst.dq_fb_oe_n);
    cmp_val("odt hold error", 0, herr);
    cmp_val("early strobe error", 0, lerr);
    close_out();
  end
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end
endmodule : tb_top
